// ===== hdl/dlir_defines.vh
// register map, field positions and reset values of the data link / code message interrupt block
`ifndef DLIR_DEFINES_VH
`define DLIR_DEFINES_VH

// printed offsets are not all multiples of four: they are word indices, byte address = 4 * index
`define DLIR_IDX_DL_STATUS   12'hB26
`define DLIR_IDX_DL_ENABLE   12'hB27
`define DLIR_IDX_CM_STATUS   12'hB70
`define DLIR_IDX_CM_ENABLE   12'hB71
`define DLIR_ADDR_W          14

// data link status / enable bit positions
`define DLIR_DL_KIND         7
`define DLIR_DL_TX_BEGIN     6
`define DLIR_DL_RX_BEGIN     5
`define DLIR_DL_TX_DONE      4
`define DLIR_DL_RX_DONE      3
`define DLIR_DL_CHECKSUM     2
`define DLIR_DL_ABORT        1
`define DLIR_DL_FLAG_SEEN    0

// code message status / enable bit positions
`define DLIR_CM_MATCH3       7
`define DLIR_CM_MATCH2       6
`define DLIR_CM_HOLD_FULL    3
`define DLIR_CM_HOLD_EMPTY   2
`define DLIR_CM_MATCH1       1
`define DLIR_CM_CHANGE       0

// writable masks; reserved bits read as zero
`define DLIR_DL_ENABLE_MASK  8'h7F
`define DLIR_CM_MASK         8'hCF
`define DLIR_RESET_VAL       8'h00

// AHB-Lite encodings
`define DLIR_HTRANS_NONSEQ   2'h2
`define DLIR_HTRANS_SEQ      2'h3
`define DLIR_HRESP_OKAY      1'h0

`endif

// ===== hdl/dlir_event_regs.v
// interrupt status and enable registers for data link controller 3 and the code message unit
//
// Summary of operation
// - set rx done on message end or full
// - set checksum error flag on FCS error
// - set abort flag on seven consecutive ones
// - set flag-seen bit on 7E octet
// - status resets zero, sticky, cleared by read
// - enable bit 6 gates tx begin
// - enable bit 5 gates rx begin
// - enable bit 4 gates tx done
// - enable bit 3 gates rx done
// - enable bits 2,1 gate checksum, abort
// - code bit 7 on validated third match
// - code bit 6 on validated second match
// - code bit 1 on validated first match
// - code bit 3 on any valid message
// - code bit 2 after programmed repeats sent
// - code bit 0 on filtered message change
// - code flags clear on read; bits 5:4 zero
// - code enable bits 7,6,3 gate their events
// - status bit 7 shows message kind
// - status bits 6,5,4 tx/rx begin, tx done
// - code enable bits 2,1,0 gate their events
`timescale 1ns/1ps
`include "dlir_defines.vh"

module dlir_event_regs (
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // data link controller 3 event strobes, one cycle each, and the message_kind level
  input  wire        tx_message_begin,
  input  wire        rx_message_begin,
  input  wire        tx_message_done,
  input  wire        rx_message_done,
  input  wire        rx_checksum_error,
  input  wire        rx_abort_seen,
  input  wire        rx_flag_seen,
  input  wire        message_kind,
  // code message unit event strobes, one cycle each
  input  wire        rx_match_third,
  input  wire        rx_match_second,
  input  wire        rx_holding_full,
  input  wire        tx_holding_empty,
  input  wire        rx_match_first,
  input  wire        rx_code_change,
  // interrupt request
  output reg         irq
);

  reg  [7:0]  dl_status_ff;
  reg  [7:0]  dl_enable_ff;
  reg  [7:0]  cm_status_ff;
  reg  [7:0]  cm_enable_ff;
  reg         kind_ff;

  // latched address phase
  reg         ap_valid_ff;
  reg         ap_write_ff;
  reg  [11:0] ap_index_ff;

  wire        ap_take;
  wire [11:0] bus_index;
  wire        bus_word;
  wire [7:0]  dl_event;
  wire [7:0]  cm_event;
  wire        rd_dl_status;
  wire        rd_cm_status;
  wire [7:0]  nxt_dl_status;
  wire [7:0]  nxt_cm_status;
  wire [7:0]  dl_shown;
  wire [7:0]  cm_shown;
  wire [7:0]  cm_keep;
  genvar      gi;
  reg  [31:0] nxt_hrdata;
  wire        nxt_irq;

  assign ap_take   = hsel & hready & htrans[1];
  assign bus_index = haddr[`DLIR_ADDR_W-1:2];
  assign bus_word  = (haddr[1:0] == 2'h0) & (haddr[31:`DLIR_ADDR_W] == 18'h00000);

  // event vectors in register bit order; bit 7 of data link is a level, not an event
  assign dl_event = {1'h0,
                     tx_message_begin,
                     rx_message_begin,
                     tx_message_done,
                     rx_message_done,
                     rx_checksum_error,
                     rx_abort_seen,
                     rx_flag_seen};
  // match, full and change strobes arrive already qualified by the filter
  assign cm_event = {rx_match_third,
                     rx_match_second,
                     2'h0,
                     rx_holding_full,
                     tx_holding_empty,
                     rx_match_first,
                     rx_code_change};

  // read clears at the data phase edge, when the master takes hrdata
  assign rd_dl_status = ap_valid_ff & ~ap_write_ff & (ap_index_ff == `DLIR_IDX_DL_STATUS);
  assign rd_cm_status = ap_valid_ff & ~ap_write_ff & (ap_index_ff == `DLIR_IDX_CM_STATUS);

  // a read clears only the bits it reported: an event landing at the address
  // phase edge is missing from the snapshot and must survive to the next read
  assign dl_shown = {1'h0, hrdata[6:0]};
  assign cm_shown = hrdata[7:0];
  assign cm_keep  = `DLIR_CM_MASK;

  // one sticky flag per bit position; set wins over the read clear
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
      wire dl_clear;
      wire cm_clear;
      assign dl_clear = rd_dl_status & dl_shown[gi];
      assign cm_clear = rd_cm_status & cm_shown[gi];
      assign nxt_dl_status[gi] = dl_event[gi] | (dl_status_ff[gi] & ~dl_clear);
      assign nxt_cm_status[gi] = cm_keep[gi] &
                                 (cm_event[gi] | (cm_status_ff[gi] & ~cm_clear));
    end
  endgenerate

  // read data is registered so it appears in the data phase following the address phase
  always @* begin
    nxt_hrdata = 32'h00000000;
    if (ap_take & ~hwrite & bus_word) begin
      case (bus_index)
        `DLIR_IDX_DL_STATUS: begin
          nxt_hrdata = {24'h000000, kind_ff, dl_status_ff[6:0]};
        end
        `DLIR_IDX_DL_ENABLE: begin
          nxt_hrdata = {24'h000000, dl_enable_ff};
        end
        `DLIR_IDX_CM_STATUS: begin
          nxt_hrdata = {24'h000000, cm_status_ff};
        end
        `DLIR_IDX_CM_ENABLE: begin
          nxt_hrdata = {24'h000000, cm_enable_ff};
        end
        default: begin
          nxt_hrdata = 32'h00000000;
        end
      endcase
    end
  end

  assign nxt_irq = (|(nxt_dl_status[6:0] & dl_enable_ff[6:0]))
                 | (|(nxt_cm_status & cm_enable_ff));

  // bus front end: zero wait states, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid_ff <= 1'h0;
      ap_write_ff <= 1'h0;
      ap_index_ff <= 12'h000;
      hrdata      <= 32'h00000000;
      hreadyout   <= 1'h1;
      hresp       <= `DLIR_HRESP_OKAY;
    end else begin
      if (hready) begin
        ap_valid_ff <= ap_take & bus_word;
        ap_write_ff <= hwrite;
        ap_index_ff <= bus_index;
      end
      // hrdata stands until the next transfer; the read clear masks with it
      if (ap_take) begin
        hrdata      <= nxt_hrdata;
      end
      hreadyout <= 1'h1;
      hresp     <= `DLIR_HRESP_OKAY;
    end
  end

  // enable registers; writes take effect at the data phase edge
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dl_enable_ff <= `DLIR_RESET_VAL;
      cm_enable_ff <= `DLIR_RESET_VAL;
    end else if (ap_valid_ff & ap_write_ff) begin
      if (ap_index_ff == `DLIR_IDX_DL_ENABLE) begin
        dl_enable_ff <= hwdata[7:0] & `DLIR_DL_ENABLE_MASK;
      end
      if (ap_index_ff == `DLIR_IDX_CM_ENABLE) begin
        cm_enable_ff <= hwdata[7:0] & `DLIR_CM_MASK;
      end
    end
  end

  // sticky status, message kind level and interrupt output
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dl_status_ff <= `DLIR_RESET_VAL;
      cm_status_ff <= `DLIR_RESET_VAL;
      kind_ff      <= 1'h0;
      irq          <= 1'h0;
    end else begin
      dl_status_ff <= nxt_dl_status;
      cm_status_ff <= nxt_cm_status;
      kind_ff      <= message_kind;
      irq          <= nxt_irq;
    end
  end

endmodule // dlir_event_regs

// ===== verification/dlir_event_regs_assertions.sv
// port assertions for the interrupt status and enable register block
`timescale 1ns/1ps
`include "dlir_defines.vh"
module dlir_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        message_kind,
  input wire        irq
);
  localparam [31:0] DLS = {18'h0, `DLIR_IDX_DL_STATUS, 2'h0};
  localparam [31:0] CMS = {18'h0, `DLIR_IDX_CM_STATUS, 2'h0};
  reg  [31:0] a_ff;
  reg         rd_ff;
  reg         wr_ff;
  wire        ap = hsel & hready & htrans[1];
  wire        dl = a_ff[31:3] == DLS[31:3];
  wire        cm = a_ff[31:3] == CMS[31:3];
  // address and direction of the transfer now in its data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_ff  <= 32'h0;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else begin
      a_ff  <= ap ? haddr : a_ff;
      rd_ff <= ap & ~hwrite;
      wr_ff <= ap & hwrite;
    end
  end
  default clocking dc @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ok; hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("answer not zero-wait okay");
  property p_upper; rd_ff |-> hrdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_cm_resv; rd_ff && cm |-> hrdata[5:4] == 2'h0; endproperty
  a_cm_resv: assert property (p_cm_resv) else $error("reserved code bits set");
  property p_en_resv; rd_ff && a_ff == DLS + 32'h4 |-> !hrdata[7]; endproperty
  a_en_resv: assert property (p_en_resv) else $error("enable bit 7 set");
  property p_unmap; rd_ff && !dl && !cm |-> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_kind; rd_ff && a_ff == DLS |-> hrdata[7] == $past(message_kind, 2); endproperty
  a_kind: assert property (p_kind) else $error("message kind bit wrong");
  property p_fall; $fell(irq) |-> $past(rd_ff | wr_ff) || $past(rd_ff | wr_ff, 2); endproperty
  a_fall: assert property (p_fall) else $error("irq fell with no access");
  property p_hold; $changed(hrdata) |-> $past(ap); endproperty
  a_hold: assert property (p_hold) else $error("read data moved unasked");
endmodule // dlir_chk

bind dlir_event_regs dlir_chk i_dlir_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .message_kind, .irq);

// ===== verification/dlir_event_regs_tb.sv
// self-checking bench for the interrupt status and enable registers
`timescale 1ns/1ps
`include "dlir_defines.vh"
module dlir_event_regs_tb;
  localparam logic [31:0] DLS = {18'h0, `DLIR_IDX_DL_STATUS, 2'h0};
  localparam logic [31:0] CMS = {18'h0, `DLIR_IDX_CM_STATUS, 2'h0};
  logic        hclk, hresetn, hsel, hwrite, message_kind, g;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, d, a;
  logic [6:0]  dl_ev;
  logic [7:0]  cm_ev, en, e, m;
  wire  [31:0] hrdata;
  wire         hready, hresp, irq;
  int          err_count, comparisons, i;
  dlir_event_regs i_dlir_event_regs (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp,
    .tx_message_begin(dl_ev[6]), .rx_message_begin(dl_ev[5]), .tx_message_done(dl_ev[4]),
    .rx_message_done(dl_ev[3]), .rx_checksum_error(dl_ev[2]), .rx_abort_seen(dl_ev[1]),
    .rx_flag_seen(dl_ev[0]), .message_kind, .rx_match_third(cm_ev[7]),
    .rx_match_second(cm_ev[6]), .rx_holding_full(cm_ev[3]), .tx_holding_empty(cm_ev[2]),
    .rx_match_first(cm_ev[1]), .rx_code_change(cm_ev[0]), .irq);
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'h1 && n < 20);
    if (hready !== 1'h1) begin
      chk("hready", {31'h0, hready}, 32'h1);
      stop_test();
    end
  endtask
  // ev is strobed during the data phase, so it meets the clearing edge of a read
  task automatic xfer(input logic w, input logic [31:0] ad, wd, input logic [6:0] ev);
    htrans <= `DLIR_HTRANS_NONSEQ;
    haddr  <= ad;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    dl_ev  <= ev;
    wait_ready();
    if (ev != 7'h00) dl_ev <= 7'h00;
    d = hrdata;
  endtask
  task automatic pulse(input logic grp, input logic [7:0] v);
    if (grp) cm_ev <= v;
    else dl_ev <= v[6:0];
    @(posedge hclk);
    cm_ev <= 8'h00;
    dl_ev <= 7'h00;
  endtask
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, message_kind} = 4'h0;
    {htrans, haddr, hwdata, dl_ev, cm_ev} = '0;
    err_count = 0;
    comparisons = 0;
    i = $urandom(62876);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 4; i++) begin
      xfer(0, (i[1] ? CMS : DLS) + 32'(i[0] * 4), 0, 0);
      chk("reset value", d, 0);
    end
    xfer(1, DLS + 32'h8, 32'hFF, 0);
    xfer(0, DLS + 32'h8, 0, 0);
    chk("unmapped", d, 0);
    xfer(1, DLS, 32'hFF, 0);
    xfer(0, DLS, 0, 0);
    chk("status write", d, 0);
    $display("reset test done");
    for (i = 0; i < 24; i++) begin
      g = i[0];
      m = g ? `DLIR_CM_MASK : `DLIR_DL_ENABLE_MASK;
      a = g ? CMS : DLS;
      en = (i < 2) ? 8'hFF : 8'($urandom);
      e = (i < 4) ? 8'hFF : 8'($urandom);
      message_kind <= i[1];
      xfer(1, a + 32'h4, {24'h0, en}, 0);
      xfer(0, a + 32'h4, 0, 0);
      chk("enable", d, en & m);
      pulse(g, e & m);
      #1 chk("irq set", 32'(irq), 32'(|(e & en & m)));
      @(posedge hclk);
      xfer(0, a, 0, 0);
      chk("status", d, (e & m) | {!g & i[1], 7'h0});
      xfer(0, a, 0, 0);
      chk("cleared", d, {!g & i[1], 7'h0});
      #1 chk("irq clear", 32'(irq), 0);
      @(posedge hclk);
    end
    $display("random test done");
    pulse(0, 8'h02);
    xfer(0, DLS, 0, 7'h01);
    chk("abort read", d, 32'h82);
    xfer(0, DLS, 0, 0);
    chk("event kept", d, 32'h81);
    dl_ev <= 7'h09;
    xfer(0, DLS, 0, 0);
    chk("early event hidden", d, 32'h80);
    xfer(0, DLS, 0, 0);
    chk("whole message", d, 32'h89);
    $display("corner test done");
    stop_test();
  end
endmodule // dlir_event_regs_tb
